// [rtl/key_match.sv]
// detects a write of one key value to one address
`timescale 1ns/1ps
module key_match #(
  parameter logic [9:0]  ADDR = 10'h000,
  parameter logic [15:0] KEY  = 16'h0000
) (
  input  wire logic        wr,
  input  wire logic [9:0]  addr,
  input  wire logic [15:0] data,
  output logic             hit
);
  // any other value at the address gives no hit
  assign hit = wr && (addr == ADDR) && (data == KEY);
endmodule // key_match

// [rtl/lock_selftest_reset_status_regs.sv]
// system-control registers: write protection, clear-on-read, reset cause, self-test
//
// Notes on behaviour
// - a 3-bit reset-cause log latches sources; any access to it clears it.
// - log bit 2 shows a global software reset since the last read.
// - log bit 1 shows a power-on reset since the last read.
// - log bit 0 shows a reset-pin assertion; reads as zero after power-on.
// - launch accepted only while both code memories are unlocked.
// - reading the self-test address returns the current outcome at any time.
// - the whole self-test takes about 2.2 ms.
// - five pattern pairs are written and read back over the memory.
// - outcome codes: 00 never, 01 running, 10 passed, 11 failed.
// - global protect makes lockable registers ignore serial writes.
// - writing bit 0 sets protection; later writes cannot clear it.
// - the release key clears all protection bits, tail bits included.
// - tail areas ignore global protect; bits 1 and 2 guard them.
// - only external host reads clear the selected registers, backdoor reads never.
// - select bit 0 makes the driver status clear on external read.
// - select bits 1 to 4 cover the four diagnosis register pairs.
// - select bits 5 to 8 cover the four core status registers.
// - a read coinciding with a core write leaves the new value intact.
// - software reset fires only when both global keys are held.
`timescale 1ns/1ps
module lock_selftest_reset_status_regs #(
  parameter int SELFTEST_MIN_CYCLES = sysctl_pkg::SELFTEST_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [9:0]                    reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic                          reg_from_host,
  output logic [15:0]                        reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic                          target_lockable,
  input  wire logic                          target_tail1,
  input  wire logic                          target_tail2,
  output logic                               write_blocked,
  output logic                               global_write_protect,
  output logic                               data_ram1_tail_protect,
  output logic                               data_ram2_tail_protect,
  input  wire logic [8:0]                    core_write_same,
  output logic [8:0]                         clear_strobe,
  input  wire logic                          pin_reset_event,
  input  wire logic                          power_on_reset_event,
  output logic                               global_reset_req,
  input  wire logic                          code_ram1_unlocked,
  input  wire logic                          code_ram2_unlocked,
  output logic                               selftest_busy,
  output logic [sysctl_pkg::RAM_AW-1:0]      ram_addr,
  output logic [15:0]                        ram_wdata,
  output logic                               ram_we,
  input  wire logic [15:0]                   ram_rdata
);
  typedef struct packed {
    logic [sysctl_pkg::LOCK_W-1:0] lock;
    logic [sysctl_pkg::COR_W-1:0]  cor_sel;
    logic [sysctl_pkg::LOG_W-1:0]  cause;
    logic [15:0]                   gr1;
    logic [15:0]                   gr2;
    logic                          gr_req;
    sysctl_pkg::selftest_outcome_e outcome;
    logic                          st_start;
    logic [15:0]                   rdata;
    logic                          rvalid;
    logic [sysctl_pkg::COR_W-1:0]  clr;
  } regs_s;

  regs_s                        st_ff;
  regs_s                        nxt;
  logic                         launch_key;
  logic                         release_key;
  logic                         cause_access;
  logic                         ext_rd;
  logic [sysctl_pkg::COR_W-1:0] cor_hit;
  logic [sysctl_pkg::LOG_W-1:0] cause_set;

  selftest_if st_if ();

  // ==========================================================
  // key detectors
  key_match #(
    .ADDR (sysctl_pkg::ADDR_SELFTEST),
    .KEY  (sysctl_pkg::KEY_SELFTEST)
  ) u_launch_key (
    .wr   (reg_wr),
    .addr (reg_addr),
    .data (reg_wdata),
    .hit  (launch_key)
  );

  key_match #(
    .ADDR (sysctl_pkg::ADDR_RELEASE_KEY),
    .KEY  (sysctl_pkg::KEY_RELEASE)
  ) u_release_key (
    .wr   (reg_wr),
    .addr (reg_addr),
    .data (reg_wdata),
    .hit  (release_key)
  );

  // ==========================================================
  // memory self-test engine
  selftest_engine #(
    .MIN_CYCLES (SELFTEST_MIN_CYCLES)
  ) u_engine (
    .clk       (clk),
    .rst_n     (rst_n),
    .ctl       (st_if.engine),
    .ram_addr  (ram_addr),
    .ram_wdata (ram_wdata),
    .ram_we    (ram_we),
    .ram_rdata (ram_rdata)
  );

  assign st_if.start = st_ff.st_start;

  // ==========================================================
  // access decode
  assign ext_rd       = reg_rd && reg_from_host;
  assign cause_access = (reg_rd || reg_wr) && (reg_addr == sysctl_pkg::ADDR_RESET_CAUSE);

  // clear-on-read target match, diagnosis targets are address pairs
  always_comb begin
    cor_hit    = '0;
    cor_hit[0] = (reg_addr == sysctl_pkg::ADDR_DRIVER_STATUS);
    cor_hit[1] = (reg_addr[9:1] == sysctl_pkg::ADDR_DIAG_C0_CH1[9:1]);
    cor_hit[2] = (reg_addr[9:1] == sysctl_pkg::ADDR_DIAG_C1_CH1[9:1]);
    cor_hit[3] = (reg_addr[9:1] == sysctl_pkg::ADDR_DIAG_C0_CH2[9:1]);
    cor_hit[4] = (reg_addr[9:1] == sysctl_pkg::ADDR_DIAG_C1_CH2[9:1]);
    cor_hit[5] = (reg_addr == sysctl_pkg::ADDR_STAT_C0_CH1);
    cor_hit[6] = (reg_addr == sysctl_pkg::ADDR_STAT_C1_CH1);
    cor_hit[7] = (reg_addr == sysctl_pkg::ADDR_STAT_C0_CH2);
    cor_hit[8] = (reg_addr == sysctl_pkg::ADDR_STAT_C1_CH2);
  end

  // reset sources seen this cycle
  always_comb begin
    cause_set                          = '0;
    cause_set[sysctl_pkg::LOG_PIN_BIT] = pin_reset_event;
    cause_set[sysctl_pkg::LOG_POR_BIT] = power_on_reset_event;
    cause_set[sysctl_pkg::LOG_SW_BIT]  = st_ff.gr_req;
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt          = st_ff;
    nxt.rvalid   = 1'b0;
    nxt.gr_req   = 1'b0;
    nxt.st_start = 1'b0;
    // protection bits can only be set by writes
    if (reg_wr && reg_addr == sysctl_pkg::ADDR_WRITE_PROTECT) begin
      nxt.lock = st_ff.lock | reg_wdata[sysctl_pkg::LOCK_W-1:0];
    end
    if (release_key) begin
      nxt.lock = '0;
    end
    if (reg_wr && reg_addr == sysctl_pkg::ADDR_COR_SELECT) begin
      nxt.cor_sel = reg_wdata[sysctl_pkg::COR_W-1:0];
    end
    // global reset keys, request then wipe
    if (reg_wr && reg_addr == sysctl_pkg::ADDR_GLOBAL_RESET1) nxt.gr1 = reg_wdata;
    if (reg_wr && reg_addr == sysctl_pkg::ADDR_GLOBAL_RESET2) nxt.gr2 = reg_wdata;
    if (st_ff.gr1 == sysctl_pkg::KEY_GLOBAL1 && st_ff.gr2 == sysctl_pkg::KEY_GLOBAL2) begin
      nxt.gr_req = 1'b1;
      nxt.gr1    = '0;
      nxt.gr2    = '0;
    end
    // log cleared on access, a new source in the same cycle wins
    if (cause_access) nxt.cause = '0;
    nxt.cause = nxt.cause | cause_set;
    // power loss wipes the older history, the pin bit is given as zero
    if (power_on_reset_event) begin
      nxt.cause                          = cause_set;
      nxt.cause[sysctl_pkg::LOG_PIN_BIT] = 1'b0;
    end
    // self-test launch and completion
    if (launch_key && code_ram1_unlocked && code_ram2_unlocked
        && st_ff.outcome != sysctl_pkg::OUT_RUNNING) begin
      nxt.st_start = 1'b1;
      nxt.outcome  = sysctl_pkg::OUT_RUNNING;
    end
    if (st_if.done) begin
      nxt.outcome = st_if.failed ? sysctl_pkg::OUT_FAILED : sysctl_pkg::OUT_PASSED;
    end
    // clear strobes: external reads only, a coinciding core write wins
    nxt.clr = cor_hit & st_ff.cor_sel & {sysctl_pkg::COR_W{ext_rd}} & ~core_write_same;
    // read data
    if (reg_rd) begin
      nxt.rvalid = 1'b1;
      nxt.rdata  = '0;
      case (reg_addr)
        sysctl_pkg::ADDR_WRITE_PROTECT: nxt.rdata[sysctl_pkg::LOCK_W-1:0] = st_ff.lock;
        sysctl_pkg::ADDR_COR_SELECT:    nxt.rdata[sysctl_pkg::COR_W-1:0]  = st_ff.cor_sel;
        sysctl_pkg::ADDR_RESET_CAUSE:   nxt.rdata[sysctl_pkg::LOG_W-1:0]  = st_ff.cause;
        sysctl_pkg::ADDR_SELFTEST:      nxt.rdata[1:0] = st_ff.outcome;
        sysctl_pkg::ADDR_RELEASE_KEY,
        sysctl_pkg::ADDR_GLOBAL_RESET1,
        sysctl_pkg::ADDR_GLOBAL_RESET2: nxt.rdata = '0;
        default:                        nxt.rvalid = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // state register, the cause log survives the main reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.cause <= nxt.cause;
    end else begin
      st_ff <= nxt;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata              = st_ff.rdata;
  assign reg_rvalid             = st_ff.rvalid;
  assign clear_strobe           = st_ff.clr;
  assign global_reset_req       = st_ff.gr_req;
  assign selftest_busy          = (st_ff.outcome == sysctl_pkg::OUT_RUNNING);
  assign global_write_protect   = st_ff.lock[sysctl_pkg::LOCK_GLOBAL_BIT];
  assign data_ram1_tail_protect = st_ff.lock[sysctl_pkg::LOCK_RAM1_BIT];
  assign data_ram2_tail_protect = st_ff.lock[sysctl_pkg::LOCK_RAM2_BIT];

  // serial writes refused by protection, reads always pass
  assign write_blocked = reg_wr && reg_from_host && (
      (target_lockable && global_write_protect) ||
      (target_tail1 && data_ram1_tail_protect) ||
      (target_tail2 && data_ram2_tail_protect));

  // ==========================================================
  // checks
  log_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cause_access && !pin_reset_event && !power_on_reset_event && !st_ff.gr_req)
    |=> st_ff.cause == '0)
    else $error("reset-cause log not cleared by access");

  sw_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.gr_req |=> st_ff.cause[sysctl_pkg::LOG_SW_BIT])
    else $error("software reset not logged");

  por_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    power_on_reset_event |=> st_ff.cause[sysctl_pkg::LOG_POR_BIT])
    else $error("power-on reset not logged");

  pin_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_reset_event && !power_on_reset_event) |=> st_ff.cause[sysctl_pkg::LOG_PIN_BIT])
    else $error("pin reset not logged");

  launch_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    (launch_key && code_ram1_unlocked && code_ram2_unlocked
     && st_ff.outcome != sysctl_pkg::OUT_RUNNING)
    |=> st_ff.st_start && st_ff.outcome == sysctl_pkg::OUT_RUNNING)
    else $error("valid launch not accepted");

  launch_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == sysctl_pkg::ADDR_SELFTEST && !st_if.done
     && (!launch_key || !code_ram1_unlocked || !code_ram2_unlocked))
    |=> !st_ff.st_start && st_ff.outcome == $past(st_ff.outcome))
    else $error("refused launch changed test state");

  outcome_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == sysctl_pkg::ADDR_SELFTEST)
    |=> reg_rvalid && reg_rdata == {14'h0000, $past(st_ff.outcome)})
    else $error("self-test read returned wrong status");

  outcome_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_if.done |=> st_ff.outcome == (st_if.failed ? sysctl_pkg::OUT_FAILED
                                                   : sysctl_pkg::OUT_PASSED))
    else $error("self-test outcome coded wrongly");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (selftest_busy && !st_if.done) |=> selftest_busy)
    else $error("running status dropped without completion");

  lock_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_from_host && target_lockable && global_write_protect) |-> write_blocked)
    else $error("write to locked register not refused");

  lock_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (global_write_protect && !release_key) |=> global_write_protect)
    else $error("protection cleared without release key");

  lock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == sysctl_pkg::ADDR_WRITE_PROTECT
     && reg_wdata[sysctl_pkg::LOCK_GLOBAL_BIT]) |=> global_write_protect)
    else $error("protection bit not set by write");

  release_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    release_key |=> st_ff.lock == '0)
    else $error("release key left protection bits set");

  tail_apart_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && target_tail1 && !target_lockable && !target_tail2
     && !data_ram1_tail_protect) |-> !write_blocked)
    else $error("global protect reached the tail area");

  backdoor_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && !reg_from_host) |=> clear_strobe == '0)
    else $error("backdoor read cleared a register");

  driver_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_rd && reg_addr == sysctl_pkg::ADDR_DRIVER_STATUS
     && st_ff.cor_sel[0] && !core_write_same[0]) |=> clear_strobe[0])
    else $error("driver status not cleared on read");

  diag_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_rd && reg_addr == sysctl_pkg::ADDR_DIAG_C1_CH2 + 10'h001
     && st_ff.cor_sel[4] && !core_write_same[4]) |=> clear_strobe[4])
    else $error("diagnosis pair not cleared on read");

  stat_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_rd && reg_addr == sysctl_pkg::ADDR_STAT_C0_CH1
     && st_ff.cor_sel[5] && !core_write_same[5]) |=> clear_strobe[5])
    else $error("core status not cleared on read");

  core_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_rd && core_write_same[0]) |=> !clear_strobe[0])
    else $error("clear overrode coinciding core write");

  reset_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_reset_req |-> $past(st_ff.gr1) == sysctl_pkg::KEY_GLOBAL1
                         && $past(st_ff.gr2) == sysctl_pkg::KEY_GLOBAL2)
    else $error("software reset without both keys");

  reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_reset_req |=> !global_reset_req)
    else $error("software reset request longer than one cycle");

  start_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.st_start |-> selftest_busy)
    else $error("self-test started without running status");

  tail_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_from_host && target_tail2 && data_ram2_tail_protect) |-> write_blocked)
    else $error("write to protected tail area not refused");

  backdoor_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && !reg_from_host) |-> !write_blocked)
    else $error("backdoor write refused by protection");
endmodule // lock_selftest_reset_status_regs

// [rtl/selftest_engine.sv]
// memory pattern walker with a floor on its run time
`timescale 1ns/1ps
module selftest_engine #(
  parameter int MIN_CYCLES = sysctl_pkg::SELFTEST_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  selftest_if.engine                         ctl,
  output logic [sysctl_pkg::RAM_AW-1:0]      ram_addr,
  output logic [15:0]                        ram_wdata,
  output logic                               ram_we,
  input  wire logic [15:0]                   ram_rdata
);
  typedef enum logic [3:0] {
    E_IDLE  = 4'b0001,
    E_WRITE = 4'b0010,
    E_READ  = 4'b0100,
    E_DONE  = 4'b1000
  } phase_e;
  typedef struct packed {
    phase_e                    phase;
    logic [3:0]                step;
    logic [sysctl_pkg::RAM_AW-1:0] addr;
    logic                      chk;
    logic [7:0]                chk_pat;
    logic                      bad;
    logic [15:0]               elapsed;
    logic                      done;
    logic                      failed;
  } eng_s;
  eng_s st_ff;
  eng_s nxt;
  logic mism;
  localparam logic [sysctl_pkg::RAM_AW-1:0] ADDR_INC = {{(sysctl_pkg::RAM_AW-1){1'b0}}, 1'b1};

  // ==========================================================
  // walk: write pattern everywhere, read it back, ten halves
  always_comb begin
    nxt      = st_ff;
    nxt.done = 1'b0;
    nxt.chk  = 1'b0;
    mism     = st_ff.chk && (ram_rdata != {2{st_ff.chk_pat}});
    nxt.bad  = st_ff.bad | mism;
    if (st_ff.phase != E_IDLE) nxt.elapsed = st_ff.elapsed + 16'h0001;
    case (st_ff.phase)
      E_IDLE: begin
        if (ctl.start) begin
          nxt.phase   = E_WRITE;
          nxt.step    = 4'h0;
          nxt.addr    = '0;
          nxt.bad     = 1'b0;
          nxt.elapsed = 16'h0000;
        end
      end
      E_WRITE: begin
        nxt.addr = st_ff.addr + ADDR_INC;
        if (&st_ff.addr) nxt.phase = E_READ;
      end
      E_READ: begin
        nxt.chk     = 1'b1;
        nxt.chk_pat = sysctl_pkg::pattern_of(st_ff.step);
        nxt.addr    = st_ff.addr + ADDR_INC;
        if (&st_ff.addr) begin
          nxt.step  = st_ff.step + 4'h1;
          nxt.phase = (st_ff.step == sysctl_pkg::LAST_STEP) ? E_DONE : E_WRITE;
        end
      end
      E_DONE: begin
        // hold the result back until the nominal run time has passed
        if (!st_ff.chk && st_ff.elapsed >= 16'(MIN_CYCLES - 1)) begin
          nxt.done   = 1'b1;
          nxt.failed = nxt.bad;
          nxt.phase  = E_IDLE;
        end
      end
      default: nxt.phase = E_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.phase <= E_IDLE;
    end else begin
      st_ff <= nxt;
    end
  end

  assign ram_addr   = st_ff.addr;
  assign ram_we     = (st_ff.phase == E_WRITE);
  assign ram_wdata  = {2{sysctl_pkg::pattern_of(st_ff.step)}};
  assign ctl.done   = st_ff.done;
  assign ctl.failed = st_ff.failed;

  // ==========================================================
  // checks
  run_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.done |-> st_ff.elapsed >= 16'(MIN_CYCLES - 1))
    else $error("self-test finished before its run time");
  fail_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mism && st_ff.phase == E_DONE) |=> st_ff.bad || st_ff.done)
    else $error("pattern mismatch not recorded");
endmodule // selftest_engine

// [rtl/selftest_if.sv]
// launch and result handshake between register group and self-test engine
`timescale 1ns/1ps
interface selftest_if;
  logic start;
  logic done;
  logic failed;
  modport ctrl   (output start, input done, input failed);
  modport engine (input start, output done, output failed);
endinterface // selftest_if

// [rtl/sysctl_pkg.sv]
// constants and types shared by the system-control register group
package sysctl_pkg;
  // ==========================================================
  // register bus geometry and field widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int LOCK_W = 3;
  localparam int LOG_W  = 3;
  localparam int COR_W  = 9;

  // ==========================================================
  // register addresses
  localparam logic [9:0] ADDR_WRITE_PROTECT = 10'h1CD;
  localparam logic [9:0] ADDR_COR_SELECT    = 10'h1CE;
  localparam logic [9:0] ADDR_RELEASE_KEY   = 10'h1CF;
  localparam logic [9:0] ADDR_GLOBAL_RESET1 = 10'h1D0;
  localparam logic [9:0] ADDR_GLOBAL_RESET2 = 10'h1D1;
  localparam logic [9:0] ADDR_RESET_CAUSE   = 10'h1D6;
  localparam logic [9:0] ADDR_SELFTEST      = 10'h1DC;
  // clear-on-read targets
  localparam logic [9:0] ADDR_DRIVER_STATUS = 10'h1B2;
  localparam logic [9:0] ADDR_DIAG_C0_CH1   = 10'h162;
  localparam logic [9:0] ADDR_DIAG_C1_CH1   = 10'h164;
  localparam logic [9:0] ADDR_DIAG_C0_CH2   = 10'h166;
  localparam logic [9:0] ADDR_DIAG_C1_CH2   = 10'h168;
  localparam logic [9:0] ADDR_STAT_C0_CH1   = 10'h108;
  localparam logic [9:0] ADDR_STAT_C1_CH1   = 10'h109;
  localparam logic [9:0] ADDR_STAT_C0_CH2   = 10'h128;
  localparam logic [9:0] ADDR_STAT_C1_CH2   = 10'h129;

  // ==========================================================
  // keys and field positions
  localparam logic [15:0] KEY_SELFTEST = 16'hB157;
  localparam logic [15:0] KEY_RELEASE  = 16'h1337;
  localparam logic [15:0] KEY_GLOBAL1  = 16'hF473;
  localparam logic [15:0] KEY_GLOBAL2  = 16'h57A1;
  localparam int LOCK_GLOBAL_BIT = 0;
  localparam int LOCK_RAM1_BIT   = 1;
  localparam int LOCK_RAM2_BIT   = 2;
  localparam int LOG_PIN_BIT     = 0;
  localparam int LOG_POR_BIT     = 1;
  localparam int LOG_SW_BIT      = 2;

  // ==========================================================
  // self-test
  typedef enum logic [1:0] {
    OUT_NEVER   = 2'h0,
    OUT_RUNNING = 2'h1,
    OUT_PASSED  = 2'h2,
    OUT_FAILED  = 2'h3
  } selftest_outcome_e;
  localparam int SELFTEST_TIME_NS = 2200000;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SELFTEST_CYCLES  = SELFTEST_TIME_NS / CLK_PERIOD_NS;
  localparam int RAM_AW           = 6;
  localparam logic [3:0] LAST_STEP = 4'h9;

  // byte written in each half of the five pattern passes
  function automatic logic [7:0] pattern_of(input logic [3:0] step);
    case (step)
      4'h1:    pattern_of = 8'h11;
      4'h2:    pattern_of = 8'h55;
      4'h3:    pattern_of = 8'hAA;
      4'h4:    pattern_of = 8'h0F;
      4'h5:    pattern_of = 8'hF0;
      4'h7:    pattern_of = 8'hFF;
      4'h8:    pattern_of = 8'hFF;
      default: pattern_of = 8'h00;
    endcase
  endfunction
endpackage

// [test/ram_model.sv]
// synchronous memory answering the self-test engine
`timescale 1ns/1ps
module ram_model (
  input  wire logic [5:0]  ram_addr,
  input  wire logic        clk,
  input  wire logic [15:0] ram_wdata,
  input  wire logic        ram_we,
  output logic      [15:0] ram_rdata
);
  logic [15:0] mem [64];
  // read data follows the address by one cycle
  always @(posedge clk) begin
    if (ram_we) mem[ram_addr] <= ram_wdata;
    ram_rdata <= mem[ram_addr];
  end
endmodule // ram_model

// [test/testbench.sv]
// bench for lock, key ports, reset log, clear-on-read and self-test
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, reg_wr, reg_rd, reg_from_host, reg_rvalid, target_lockable, target_tail1;
  logic target_tail2, write_blocked, global_write_protect, data_ram1_tail_protect;
  logic data_ram2_tail_protect, pin_reset_event, power_on_reset_event, global_reset_req;
  logic code_ram1_unlocked, code_ram2_unlocked, selftest_busy, ram_we;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ram_wdata, ram_rdata, seed, r;
  logic [8:0]  core_write_same, clear_strobe;
  logic [5:0]  ram_addr;
  logic [15:0] exp_q [$];
  logic [9:0]  tgt [9] = '{10'h1B2, 10'h162, 10'h164, 10'h166, 10'h168,
                           10'h108, 10'h109, 10'h128, 10'h129};
  int          fail_count, n_checks, i;
  lock_selftest_reset_status_regs #(.SELFTEST_MIN_CYCLES(200)) dut (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_from_host, .reg_rdata, .reg_rvalid, .target_lockable,
    .target_tail1, .target_tail2, .write_blocked, .global_write_protect, .data_ram1_tail_protect,
    .data_ram2_tail_protect, .core_write_same, .clear_strobe, .pin_reset_event,
    .power_on_reset_event, .global_reset_req, .code_ram1_unlocked, .code_ram2_unlocked,
    .selftest_busy, .ram_addr, .ram_wdata, .ram_we, .ram_rdata);
  ram_model mem (.clk, .ram_addr, .ram_wdata, .ram_we, .ram_rdata);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one access per call, strobe dropped at the next falling edge
  task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic h);
    @(negedge clk) {reg_addr, reg_wdata, reg_from_host, reg_wr} = {a, d, h, 1'b1};
    @(negedge clk) reg_wr = 0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e, input logic h);
    if ((a >= 10'h1CD && a <= 10'h1D1) || a == 10'h1D6 || a == 10'h1DC) exp_q.push_back(e);
    @(negedge clk) {reg_addr, reg_from_host, reg_rd} = {a, h, 1'b1};
    @(negedge clk) reg_rd = 0;
  endtask
  // read answers matched against the oldest note
  always @(negedge clk) if (reg_rvalid === 1'b1) begin
    if (exp_q.size() == 0) chk(reg_rdata, 16'hDEAD);
    else chk(reg_rdata, exp_q.pop_front());
  end
  initial begin
    {reg_wr, reg_rd, reg_from_host, target_lockable, target_tail1, target_tail2} = 0;
    {code_ram1_unlocked, code_ram2_unlocked, core_write_same, reg_addr, reg_wdata} = 0;
    {rst_n, pin_reset_event, power_on_reset_event, seed} = {3'b001, 16'h041D};
    repeat (4) @(negedge clk);
    {rst_n, power_on_reset_event} = 2'b10;
    rd(10'h1CD, 0, 1); rd(10'h1DC, 0, 1);
    rd(10'h1D6, 16'h0002, 1);
    @(negedge clk) pin_reset_event = 1;
    @(negedge clk) pin_reset_event = 0;
    rd(10'h1D6, 16'h0001, 1); rd(10'h1D6, 0, 1);
    wr(10'h1D0, 16'hF473, 1); wr(10'h1D1, 16'h57A1, 1); chk(global_reset_req, 0);
    @(negedge clk) chk(global_reset_req, 1);
    @(negedge clk) chk(global_reset_req, 0);
    rd(10'h1D6, 16'h0004, 1);
    $display("reset log test done");
    wr(10'h1CD, 16'h0007, 1); wr(10'h1CD, 0, 1); rd(10'h1CD, 16'h0007, 1);
    @(negedge clk) {target_lockable, reg_addr, reg_from_host, reg_wr} = {1'b1, 10'h140, 2'b11};
    #1 chk(write_blocked, 1);
    @(negedge clk) {target_lockable, reg_wr} = 0;
    @(negedge clk) {target_tail2, reg_wr} = 2'b11;
    #1 chk(write_blocked, 1);
    @(negedge clk) {target_tail2, reg_wr} = 0;
    wr(10'h1CF, 16'h1338, 1); chk(global_write_protect, 1);
    wr(10'h1CF, 16'h1337, 1);
    chk({global_write_protect, data_ram1_tail_protect, data_ram2_tail_protect}, 0);
    wr(10'h1CD, 16'h0001, 1);
    @(negedge clk) {target_tail1, reg_addr, reg_wr} = {1'b1, 10'h140, 1'b1};
    #1 chk(write_blocked, 0);
    @(negedge clk) {target_tail1, reg_wr} = 0;
    wr(10'h1CF, 16'h1337, 1); chk(global_write_protect, 0);
    $display("lock test done");
    r = (xs() | 16'h0011) & 16'h01FF;
    wr(10'h1CE, r, 1); rd(10'h1CE, r, 1);
    for (i = 0; i < 9; i++) begin
      rd(tgt[i], 0, 1);
      chk(clear_strobe, r & (16'h0001 << i));
    end
    rd(10'h1B2, 0, 0); chk(clear_strobe, 0);
    rd(10'h169, 0, 1); chk(clear_strobe, 16'h0010);
    core_write_same = 9'h001;
    rd(10'h1B2, 0, 1); chk(clear_strobe, 0);
    core_write_same = 0;
    $display("clear-on-read test done");
    wr(10'h1DC, 16'hB157, 1); rd(10'h1DC, 0, 1);
    {code_ram1_unlocked, code_ram2_unlocked} = 2'b11;
    wr(10'h1DC, 16'hB158, 1); rd(10'h1DC, 0, 1);
    wr(10'h1DC, 16'hB157, 1); rd(10'h1DC, 16'h0001, 1);
    for (i = 0; i < 5000 && selftest_busy !== 1'b0; i++) @(negedge clk);
    if (i == 5000) fail_count++;
    rd(10'h1DC, 16'h0002, 1);
    repeat (2) @(negedge clk);
    $display("self-test test done");
    results();
  end
endmodule // testbench
